// [tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the strobed test-set bus controller.
module tb_top;
    import tsb_pkg::*;
    logic i_clk, i_nrst, i_req, i_read, i_sweep_req, i_holdoff_n, i_intr_n;
    logic [12:0] i_addr, i_wdata, o_ad, o_rdata, p_ad, ad_wire, last_q;
    logic o_ad_oe, o_addr_strobe_n, o_data_strobe_n, o_read_not_write, o_busy, o_done, o_sweep_run, o_sweep_abort;
    logic p_oe;
    logic [3:0] o_unit_select;
    int bad_count = 0;
    int checks = 0;

    tsb_bus i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_read(i_read), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_sweep_req(i_sweep_req), .i_holdoff_n(i_holdoff_n), .i_intr_n(i_intr_n),
        .i_ad(ad_wire), .o_ad(o_ad), .o_ad_oe(o_ad_oe), .o_addr_strobe_n(o_addr_strobe_n),
        .o_data_strobe_n(o_data_strobe_n), .o_read_not_write(o_read_not_write), .o_unit_select(o_unit_select),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_sweep_run(o_sweep_run),
        .o_sweep_abort(o_sweep_abort));
    tsb_test_set i_set (.i_clk(i_clk), .i_addr_strobe_n(o_addr_strobe_n), .i_data_strobe_n(o_data_strobe_n),
        .i_read_not_write(o_read_not_write), .i_ad(ad_wire), .o_ad(p_ad), .o_ad_oe(p_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Resolve the shared lines; undriven lines show the inverse of their last level.
    assign ad_wire = o_ad_oe ? o_ad : (p_oe ? p_ad : ~last_q);
    always @(posedge i_clk) if (o_ad_oe || p_oe) last_q <= ad_wire;

    // Clock at 100 ns period.
    initial begin
        i_clk = 0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One bus cycle; strobe widths and overlap are watched throughout, direction and address lanes under the address strobe, write lanes under the data strobe.
    task automatic bus_cycle(input logic rd, input logic [12:0] addr, input logic [12:0] wd,
                             input logic [12:0] exp);
        int na, nd, ovl, k, done_at;
        logic got_done;
        na = 0; nd = 0; ovl = 0; got_done = 0; done_at = -1;
        i_req = 1; i_read = rd; i_addr = addr; i_wdata = wd;
        @(negedge i_clk);
        i_req = 0;
        for (k = 0; k < 40; k++) begin
            if (k == 0) chk("busy taken", {12'h000, o_busy}, 13'h0001);
            if (!o_addr_strobe_n) begin
                na++;
                chk("direction", {12'h000, o_read_not_write}, {12'h000, rd});
                chk("address lanes", ad_wire, addr);
            end
            if (!o_data_strobe_n) begin
                nd++;
                if (!o_addr_strobe_n) ovl++;
                if (!rd) chk("write lanes", ad_wire, wd);
            end
            chk("unit select", {9'h000, o_unit_select}, 13'h0000);
            if (o_done) begin
                got_done = 1;
                done_at = k;
                if (rd) chk("read data", o_rdata, exp);
            end
            @(negedge i_clk);
        end
        chk("addr strobe width", {12'h000, na >= 10}, 13'h0001);
        chk("data strobe width", {12'h000, nd >= 10}, 13'h0001);
        chk("strobe overlap", 13'(ovl), 13'h0000);
        chk("cycle done", {12'h000, got_done}, 13'h0001);
        chk("done cycle", 13'(done_at), 13'(2 * STROBE_CYC + 3));
        chk("busy released", {12'h000, o_busy}, 13'h0000);
    endtask

    // Holdoff keeps the sweep from starting and releasing it lets the sweep run.
    task automatic t_holdoff();
        i_sweep_req = 1; i_holdoff_n = 0;
        repeat (3) @(negedge i_clk);
        chk("run in holdoff", {12'h000, o_sweep_run}, 13'h0000);
        i_holdoff_n = 1;
        repeat (3) @(negedge i_clk);
        chk("run released", {12'h000, o_sweep_run}, 13'h0001);
    endtask

    // An interrupt held low leaves the sweep alone for 95 cycles; within ten more cycles it aborts the sweep.
    task automatic t_intr();
        logic seen;
        seen = 0;
        i_intr_n = 0;
        repeat (95) @(negedge i_clk);
        chk("early abort", {12'h000, o_sweep_abort}, 13'h0000);
        chk("early run", {12'h000, o_sweep_run}, 13'h0001);
        repeat (10) begin
            @(negedge i_clk);
            seen = seen | o_sweep_abort;
        end
        chk("abort seen", {12'h000, seen}, 13'h0001);
        chk("run after abort", {12'h000, o_sweep_run}, 13'h0000);
        i_intr_n = 1; i_sweep_req = 0;
    endtask

    task automatic test_done();
        $display("mismatches %0d of %0d checks", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence: reset, back-to-back writes to two units, read-backs, then sweep control.
    initial begin
        i_nrst = 0; i_req = 0; i_read = 0; i_addr = 13'h0000; i_wdata = 13'h0000;
        i_sweep_req = 0; i_holdoff_n = 1; i_intr_n = 1; last_q = 13'h0000;
        repeat (12) @(negedge i_clk);
        i_nrst = 1;
        bus_cycle(1'b0, 13'h0002, 13'h1a5c, 13'h0000);
        bus_cycle(1'b0, 13'h1fff, 13'h05a3, 13'h0000);
        bus_cycle(1'b1, 13'h0002, 13'h0000, 13'h1a5c);
        bus_cycle(1'b1, 13'h1fff, 13'h0000, 13'h05a3);
        t_holdoff();
        t_intr();
        test_done();
    end

    // Watchdog cuts a hang short.
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
endmodule // tb_top

// [tsb_bus.sv]
`timescale 1ns/1ps
// Analyzer-side controller of the strobed test-set bus.
module tsb_bus
    import tsb_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_req,
    input  wire logic                      i_read,
    input  wire logic [tsb_pkg::AD_W-1:0]  i_addr,
    input  wire logic [tsb_pkg::AD_W-1:0]  i_wdata,
    input  wire logic                      i_sweep_req,
    input  wire logic                      i_holdoff_n,
    input  wire logic                      i_intr_n,
    input  wire logic [tsb_pkg::AD_W-1:0]  i_ad,
    output logic      [tsb_pkg::AD_W-1:0]  o_ad,
    output logic                           o_ad_oe,
    output logic                           o_addr_strobe_n,
    output logic                           o_data_strobe_n,
    output logic                           o_read_not_write,
    output logic      [tsb_pkg::SEL_W-1:0] o_unit_select,
    output logic                           o_busy,
    output logic                           o_done,
    output logic      [tsb_pkg::AD_W-1:0]  o_rdata,
    output logic                           o_sweep_run,
    output logic                           o_sweep_abort
);
    import tsb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    tsb_state_e       state_q;
    logic [AD_W-1:0]  wdata_q;
    logic             read_q;
    logic [CNT_W-1:0] intr_cnt_q;
    logic             intr_hit;
    logic [CNT_W-1:0] low_seen_q;
    tsb_cnt_if        strb ();

    // Strobe width timer.
    tsb_timer #(.LAST(STROBE_LAST)) u_strobe_timer (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .cnt    (strb.timer)
    );

    // Start the timer when a strobe phase opens.
    assign strb.start = (state_q == ST_IDLE && i_req) || (state_q == ST_GAP);

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer: address phase, then data phase.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_IDLE;
            wdata_q <= AD_ZERO;
            read_q  <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (i_req) begin
                        state_q <= ST_ADDR; // RQ10
                        wdata_q <= i_wdata;
                        read_q  <= i_read;
                    end
                end
                ST_ADDR: if (strb.done) begin
                    state_q <= ST_GAP; // RQ3
                end
                ST_GAP:  state_q <= ST_DATA; // RQ10
                ST_DATA: if (strb.done) begin
                    state_q <= ST_DONE; // RQ4
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Registered pin drive; address first, latched data in data phase.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ad             <= AD_ZERO;
            o_ad_oe          <= 1'b0;
            o_addr_strobe_n  <= 1'b1;
            o_data_strobe_n  <= 1'b1;
            o_read_not_write <= 1'b1;
        end else begin
            if (state_q == ST_IDLE && i_req) begin
                o_ad             <= i_addr; // RQ6
                o_ad_oe          <= 1'b1; // RQ1
                o_addr_strobe_n  <= 1'b0; // RQ3
                o_read_not_write <= i_read; // RQ5
            end else if (state_q == ST_ADDR && strb.done) begin
                o_addr_strobe_n <= 1'b1; // RQ3
                o_ad            <= wdata_q; // RQ6
                o_ad_oe         <= !read_q; // RQ6
            end else if (state_q == ST_GAP) begin
                o_data_strobe_n <= 1'b0; // RQ10
            end else if (state_q == ST_DATA && strb.done) begin
                o_data_strobe_n <= 1'b1; // RQ4
            end else if (state_q == ST_DONE) begin
                o_ad_oe          <= 1'b0;
                o_read_not_write <= 1'b1;
            end
        end
    end

    // Capture read data at the end of the data phase, any of sixteen units.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= AD_ZERO;
            o_done  <= 1'b0;
            o_busy  <= 1'b0;
        end else begin
            o_done <= (state_q == ST_DATA) && strb.done;
            o_busy <= (state_q != ST_IDLE) || i_req;
            if (state_q == ST_DATA && strb.done && read_q) begin
                o_rdata <= i_ad; // RQ2
            end
        end
    end

    // Select outputs are held at zero.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_unit_select <= SEL_VALUE;
        end else begin
            o_unit_select <= SEL_VALUE; // RQ9
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt low-time filter.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            intr_cnt_q <= CNT_ZERO;
        end else if (i_intr_n) begin
            intr_cnt_q <= CNT_ZERO;
        end else if (intr_cnt_q != INTR_LAST) begin
            intr_cnt_q <= intr_cnt_q + 8'h01; // RQ7
        end
    end
    assign intr_hit = !i_intr_n && (intr_cnt_q == INTR_LAST);

    // Sweep gating: holdoff stops it, long interrupt aborts it.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sweep_run   <= 1'b0;
            o_sweep_abort <= 1'b0;
        end else begin
            o_sweep_abort <= intr_hit && o_sweep_run; // RQ7
            o_sweep_run   <= i_sweep_req && i_holdoff_n && !intr_hit; // RQ8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    las_width_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ3
        $fell(o_addr_strobe_n) |-> !o_addr_strobe_n [*8] ##1 !o_addr_strobe_n [*2])
        else $error("address strobe too short");
    lds_width_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
        $fell(o_data_strobe_n) |-> !o_data_strobe_n [*8] ##1 !o_data_strobe_n [*2])
        else $error("data strobe too short");
    strobe_excl_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ10
        !(!o_addr_strobe_n && !o_data_strobe_n))
        else $error("both strobes low");
    lds_after_las_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ10
        $rose(o_addr_strobe_n) |-> ##1 $fell(o_data_strobe_n))
        else $error("data strobe did not follow address");
    dir_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ5
        (!o_data_strobe_n && !$fell(o_data_strobe_n)) |-> $stable(o_read_not_write))
        else $error("direction changed in data phase");
    read_release_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
        (!o_data_strobe_n && o_read_not_write) |-> !o_ad_oe)
        else $error("driving lines during read");
    select_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ9
        o_unit_select == SEL_VALUE)
        else $error("select not zero");
    holdoff_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ8
        !i_holdoff_n |=> !o_sweep_run)
        else $error("sweep ran during holdoff");
    intr_abort_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ7
        (o_sweep_run && !i_intr_n && low_seen_q == INTR_LAST) |=> (!o_sweep_run && o_sweep_abort))
        else $error("long interrupt did not abort");
    abort_qualified_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ7
        o_sweep_abort |-> (!$past(i_intr_n) && $past(low_seen_q) == INTR_LAST))
        else $error("abort without a long interrupt");
    holdoff_run_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ8
        o_sweep_run |-> $past(i_holdoff_n))
        else $error("sweep started during holdoff");

    // The shared lines must not move while a strobe marks them valid.
    addr_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
        (!o_addr_strobe_n && !$fell(o_addr_strobe_n)) |-> $stable(o_ad))
        else $error("address moved under address strobe");
    data_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
        (!o_data_strobe_n && !$fell(o_data_strobe_n)) |-> ($stable(o_ad) && $stable(o_ad_oe)))
        else $error("data lines moved under data strobe");
    write_drive_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
        (!o_data_strobe_n && !o_read_not_write) |-> o_ad_oe)
        else $error("write data not driven");
    addr_drive_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ1
        !o_addr_strobe_n |-> o_ad_oe)
        else $error("address not driven");
    done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
        o_done |=> !o_done)
        else $error("done held longer than one cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Checker helper: counts consecutive low interrupt samples, saturating at the abort limit.
    // Kept apart from the filter above so the abort checks do not lean on the logic they watch.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_seen_q <= CNT_ZERO;
        end else if (i_intr_n) begin
            low_seen_q <= CNT_ZERO;
        end else if (low_seen_q != INTR_LAST) begin
            low_seen_q <= low_seen_q + 8'h01;
        end
    end
endmodule // tsb_bus

// [tsb_cnt_if.sv]
`timescale 1ns/1ps
// Carries a request and completion between the sequencer and a cycle timer.
interface tsb_cnt_if;
    logic start;
    logic done;
    modport owner (output start, input done);
    modport timer (input start, output done);
endinterface

// [tsb_pkg.sv]
// Functional notes
// RQ1: Thirteen shared address/data lines, three control lines, one open-collector interrupt.
// RQ2: Up to sixteen daisy-chained test sets answer on the shared lines.
// RQ3: Address strobe is active low and held low at least one microsecond.
// RQ4: Data strobe is active low and held low at least one microsecond.
// RQ5: Direction line is high for a read and low for a write.
// RQ6: Shared lines carry address first, then data held latched during data phase.
// RQ7: Interrupt input low for ten microseconds aborts the running sweep.
// RQ8: While holdoff input is low no sweep starts or continues.
// RQ9: Four test-set select outputs are always driven to logic zero.
// RQ10: Each cycle presents address with address strobe, then data strobe afterwards.
package tsb_pkg;
    localparam int unsigned AD_W         = 13;
    localparam int unsigned SEL_W        = 4;
    localparam int unsigned MAX_UNITS    = 16;
    localparam int unsigned CLK_MHZ      = 10;
    localparam int unsigned STROBE_US    = 1;
    localparam int unsigned INTR_US      = 10;
    localparam int unsigned STROBE_CYC   = (STROBE_US * CLK_MHZ < 1) ? 1 : STROBE_US * CLK_MHZ;
    localparam int unsigned INTR_CYC     = (INTR_US * CLK_MHZ < 1) ? 1 : INTR_US * CLK_MHZ;
    localparam int unsigned CNT_W        = 8;
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] INTR_LAST   = CNT_W'(INTR_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 8'h00;
    localparam logic [SEL_W-1:0] SEL_VALUE   = 4'h0;
    localparam logic [AD_W-1:0]  AD_ZERO     = 13'h0000;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA, ST_DONE} tsb_state_e;
endpackage

// [tsb_test_set.sv]
`timescale 1ns/1ps
// Behavioural test set on the far side: one data word per unit, picked by the low address bits.
module tsb_test_set (
    input  wire logic        i_clk,
    input  wire logic        i_addr_strobe_n,
    input  wire logic        i_data_strobe_n,
    input  wire logic        i_read_not_write,
    input  wire logic [12:0] i_ad,
    output logic      [12:0] o_ad,
    output logic             o_ad_oe
);
    logic [12:0] addr_q;
    logic [12:0] mem_q [16];

    ////////////////////////////////////////////////////////////////////////////////
    // Latch the address under the address strobe and write data under the data strobe.
    always @(posedge i_clk) begin
        if (!i_addr_strobe_n) begin
            addr_q <= i_ad;
        end
        if (!i_data_strobe_n && !i_read_not_write) begin
            mem_q[addr_q[3:0]] <= i_ad;
        end
    end

    // Drive read data only while the data strobe is low, so the lines are free otherwise.
    assign o_ad_oe = !i_data_strobe_n && i_read_not_write;
    assign o_ad    = mem_q[addr_q[3:0]];
endmodule // tsb_test_set

// [tsb_timer.sv]
`timescale 1ns/1ps
// Counts a fixed number of cycles after start and then pulses done.
module tsb_timer #(
    parameter logic [7:0] LAST = 8'h00
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    tsb_cnt_if.timer  cnt
);
    import tsb_pkg::*;
    logic [CNT_W-1:0] cnt_q;
    logic             run_q;
    logic             done_q;

    // Run the count and flag its last cycle.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q  <= CNT_ZERO;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (cnt.start) begin
                cnt_q <= CNT_ZERO;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == LAST) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
    assign cnt.done = done_q;
endmodule // tsb_timer
